// File: qcirq_enc_model.sv
// Purpose: two-phase encoder driving one pair of phase pins
// Assumes: each level held at least three clocks, pins rest low between moves
// Notes: forward cycle has a leading b; backward cycle has b leading a
`timescale 1ns/1ns
module qcirq_enc_model (
  input  wire logic clk_i,
  output logic      a_o,
  output logic      b_o
);
  initial begin
    a_o = 1'b0;
    b_o = 1'b0;
  end

  // only one pin changes per step, so phase gap equals the hold time
  task automatic move(input logic fwd, input int n, input int hold);
    logic [7:0] seq;
    seq = fwd ? 8'hB4 : 8'h78;
    repeat (n) begin
      for (int k = 3; k >= 0; k--) begin
        repeat (hold) @(posedge clk_i);
        {a_o, b_o} <= seq[2*k +: 2];
      end
    end
  endtask
endmodule // qcirq_enc_model

// File: qcirq_flags.sv
// Purpose: status flags, enables and request gating for one channel
// Assumes: set and clear arrive as one-cycle masks
// Notes: a set in the cycle of its clear wins, so no event is lost
`timescale 1ns/1ns
module qcirq_flags #(
  parameter logic [5:0] SRC_MASK = qcirq_pkg::MASK_FOUR
) (
  input  logic       clk_i,
  input  logic       resetn_i,
  input  logic [5:0] set_i,
  input  logic [5:0] clr_i,
  input  logic [5:0] ier_i,
  output logic [5:0] flags_o,
  output logic [5:0] irq_o,
  output logic       req_o,
  output logic [2:0] src_o
);
  typedef struct packed {
    logic [5:0] flags;
  } qcirq_flg_s;
  qcirq_flg_s q, d;

  always_comb begin
    d.flags = ((q.flags & ~clr_i) | set_i) & SRC_MASK;
    src_o = qcirq_pkg::SRC_NONE;
    for (int k = 5; k >= 0; k--) begin
      if (irq_o[k]) src_o = 3'(k);
    end
  end

  assign flags_o = q.flags;
  assign irq_o   = q.flags & ier_i;
  assign req_o   = |irq_o;

  always_ff @(posedge clk_i) begin
    if (!resetn_i) q <= '0;
    else q <= d;
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!resetn_i);
  set_wins_a: assert property ((set_i & clr_i & SRC_MASK) != 6'h00 |=> (flags_o & $past(set_i & clr_i & SRC_MASK)) == $past(set_i & clr_i & SRC_MASK)) else $error("set lost to clear");
  flag_clear_a: assert property ((clr_i & ~set_i & flags_o) != 6'h00 |=> (irq_o & $past(clr_i & ~set_i)) == 6'h00) else $error("request outlived flag");
  fixed_prio_a: assert property (req_o |-> irq_o[src_o] && (irq_o & ((6'h01 << src_o) - 6'h01)) == 6'h00) else $error("priority wrong");
endmodule // qcirq_flags

// File: qcirq_phase_dec.sv
// Purpose: two-phase edge decoder for one channel
// Assumes: pins asynchronous to clk_i, slower than 2.5 clocks per level
// Notes: up_o/dn_o are one-cycle pulses, two clocks after the pin edge
`timescale 1ns/1ns
module qcirq_phase_dec (
  input  logic                  clk_i,
  input  logic                  resetn_i,
  input  logic                  a_i,
  input  logic                  b_i,
  input  qcirq_pkg::qcirq_mode_e mode_i,
  output logic                  up_o,
  output logic                  dn_o
);
  typedef struct packed {
    logic a1, a2, ap, b1, b2, bp;
  } qcirq_dec_s;
  qcirq_dec_s q, d;
  logic ar, af, br, bf;

  always_comb begin
    d = '{a1: a_i, a2: q.a1, ap: q.a2, b1: b_i, b2: q.b1, bp: q.b2};
    ar = q.a2 & ~q.ap;
    af = ~q.a2 & q.ap;
    br = q.b2 & ~q.bp;
    bf = ~q.b2 & q.bp;
    case (mode_i)
      qcirq_pkg::QC_M1: begin
        up_o = (br & q.a2) | (bf & ~q.a2) | (ar & ~q.b2) | (af & q.b2);
        dn_o = (bf & q.a2) | (br & ~q.a2) | (af & ~q.b2) | (ar & q.b2);
      end
      qcirq_pkg::QC_M2: begin
        up_o = af & q.b2;
        dn_o = af & ~q.b2;
      end
      qcirq_pkg::QC_M3: begin
        up_o = af & q.b2;
        dn_o = bf & q.a2;
      end
      qcirq_pkg::QC_M4: begin
        up_o = (br & q.a2) | (bf & ~q.a2);
        dn_o = (bf & q.a2) | (br & ~q.a2);
      end
      default: begin
        up_o = 1'b0;
        dn_o = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (!resetn_i) q <= '0;
    else q <= d;
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!resetn_i);
  m2_count_a: assert property ((mode_i == qcirq_pkg::QC_M2) && $stable(mode_i) && $fell(a_i) && b_i && $past(b_i) |-> ##2 (up_o && !dn_o)) else $error("mode 2 up missed");
  m3_down_a: assert property ((mode_i == qcirq_pkg::QC_M3) && $stable(mode_i) && $fell(b_i) && a_i && $past(a_i) |-> ##2 (dn_o && !up_o)) else $error("mode 3 down missed");
  m4_a_ignored_a: assert property ((mode_i == qcirq_pkg::QC_M4) && $stable(mode_i) && $changed(a_i) && $stable(b_i) && $past(b_i) == $past(b_i, 2) |-> ##2 !(up_o || dn_o)) else $error("mode 4 counted a");
endmodule // qcirq_phase_dec

// File: qcirq_pkg.sv
// Purpose: constants and types of the quadrature counter and flag block
// Assumes: one 10 MHz clock, AXI4-Lite register access
// Notes: each channel owns eight words, 0x20 bytes apart
package qcirq_pkg;
  localparam int NCH = 6;
  localparam int CW  = 16;
  localparam int AW  = 8;
  localparam logic [2:0] REG_CTRL = 3'h0;
  localparam logic [2:0] REG_IER  = 3'h1;
  localparam logic [2:0] REG_FLAG = 3'h2;
  localparam logic [2:0] REG_CNT  = 3'h3;
  localparam logic [2:0] REG_GRA  = 3'h4;
  localparam logic [2:0] REG_GRC  = 3'h6;
  localparam int CTL_RUN   = 0;
  localparam int CTL_PHASE = 1;
  localparam int CTL_MODE  = 2;
  localparam int CTL_CAPB  = 4;
  localparam int CTL_CAPA  = 5;
  localparam int CTL_BUF   = 6;
  localparam int FLAG_DIR  = 7;
  localparam int SRC_A = 0;
  localparam int SRC_B = 1;
  localparam int SRC_C = 2;
  localparam int SRC_D = 3;
  localparam int SRC_V = 4;
  localparam int SRC_U = 5;
  localparam logic [5:0]  MASK_FOUR = 6'h1F;
  localparam logic [5:0]  MASK_TWO  = 6'h33;
  localparam logic [15:0] CNT_MAX   = 16'hFFFF;
  localparam logic [15:0] CNT_MIN   = 16'h0000;
  localparam logic [15:0] CNT_ONE   = 16'h0001;
  localparam logic [2:0]  SRC_NONE  = 3'h7;
  localparam logic [1:0]  RESP_OK   = 2'h0;
  localparam logic [1:0]  RESP_ERR  = 2'h2;

  typedef enum logic [1:0] {
    QC_M1 = 2'b00,
    QC_M2 = 2'b01,
    QC_M3 = 2'b10,
    QC_M4 = 2'b11
  } qcirq_mode_e;

  function automatic logic has_four(input int ch);
    return (ch == 0) || (ch == 3);
  endfunction

  function automatic logic [5:0] src_mask(input int ch);
    return has_four(ch) ? MASK_FOUR : MASK_TWO;
  endfunction
endpackage

// File: qcirq_top.sv
// Purpose: quadrature counting, capture coupling and flags of six timer channels
// Assumes: AXI4-Lite master, one write and one read in flight at a time
// Notes: ext_clock pins are sampled on clk_i; phase inputs need 2.5 clock levels
//
// Decided for this implementation: register access over AXI4-Lite and the address map.
`timescale 1ns/1ns
module qcirq_top (
  input  logic                     clk_i,
  input  logic                     resetn_i,
  input  logic [qcirq_pkg::AW-1:0] s_axi_awaddr,
  input  logic                     s_axi_awvalid,
  output logic                     s_axi_awready,
  input  logic [31:0]              s_axi_wdata,
  input  logic [3:0]               s_axi_wstrb,
  input  logic                     s_axi_wvalid,
  output logic                     s_axi_wready,
  output logic [1:0]               s_axi_bresp,
  output logic                     s_axi_bvalid,
  input  logic                     s_axi_bready,
  input  logic [qcirq_pkg::AW-1:0] s_axi_araddr,
  input  logic                     s_axi_arvalid,
  output logic                     s_axi_arready,
  output logic [31:0]              s_axi_rdata,
  output logic [1:0]               s_axi_rresp,
  output logic                     s_axi_rvalid,
  input  logic                     s_axi_rready,
  input  logic                     ext_clock_pin_a_i,
  input  logic                     ext_clock_pin_b_i,
  input  logic                     ext_clock_pin_c_i,
  input  logic                     ext_clock_pin_d_i,
  input  logic [5:0]               dma_ack_i,
  output logic [35:0]              src_irq_o,
  output logic [5:0]               ch_irq_o,
  output logic [17:0]              ch_irq_src_o,
  output logic [5:0]               dma_req_o
);
  typedef struct packed {
    logic [5:0][15:0]      cnt;
    logic [5:0][3:0][15:0] gr;
    logic [5:0][7:0]       ctl;
    logic [5:0][5:0]       ier;
    logic [5:0]            dir;
    logic                  bvalid;
    logic [1:0]            bresp;
    logic                  rvalid;
    logic [1:0]            rresp;
    logic [31:0]           rdata;
  } qcirq_state_s;

  qcirq_state_s qs, qd;
  logic [5:0]            dec_up, dec_dn, cup, cdn, ovf, unf;
  logic [5:0][15:0]      cnt_n;
  logic [5:0][3:0]       match;
  logic [5:0][5:0]       set_v, clr_v, flags;
  logic                  capb0, capa1, capb1;
  logic                  wr_fire, wr_ok;
  logic [2:0]            wch, wreg, rch, rreg;

  // channel in [7:5], word in [4:2]; c and d words exist only on four-register channels
  function automatic logic reg_ok(input logic [2:0] ch, input logic [2:0] rg);
    return (int'(ch) < qcirq_pkg::NCH) &&
           (rg < qcirq_pkg::REG_GRC || qcirq_pkg::has_four(int'(ch)));
  endfunction

  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] wd,
                                          input logic [3:0] st);
    return {st[1] ? wd[15:8] : old[15:8], st[0] ? wd[7:0] : old[7:0]};
  endfunction

  // phase decoders only where the channel supports them
  genvar g;
  generate
    for (g = 0; g < qcirq_pkg::NCH; g++) begin : g_dec
      if (qcirq_pkg::has_four(g)) begin : g_none
        assign dec_up[g] = 1'b0;
        assign dec_dn[g] = 1'b0;
      end else begin : g_ph
        logic pa, pb;
        assign pa = (g == 1 || g == 5) ? ext_clock_pin_a_i : ext_clock_pin_c_i;
        assign pb = (g == 1 || g == 5) ? ext_clock_pin_b_i : ext_clock_pin_d_i;
        qcirq_phase_dec u_dec (
          .clk_i    (clk_i),
          .resetn_i (resetn_i),
          .a_i      (pa),
          .b_i      (pb),
          .mode_i   (qcirq_pkg::qcirq_mode_e'(qs.ctl[g][qcirq_pkg::CTL_MODE +: 2])),
          .up_o     (dec_up[g]),
          .dn_o     (dec_dn[g])
        );
      end
      qcirq_flags #(
        .SRC_MASK (qcirq_pkg::src_mask(g))
      ) u_flg (
        .clk_i    (clk_i),
        .resetn_i (resetn_i),
        .set_i    (set_v[g]),
        .clr_i    (clr_v[g]),
        .ier_i    (qs.ier[g]),
        .flags_o  (flags[g]),
        .irq_o    (src_irq_o[g*6 +: 6]),
        .req_o    (ch_irq_o[g]),
        .src_o    (ch_irq_src_o[g*3 +: 3])
      );
      assign dma_req_o[g] = src_irq_o[g*6 + qcirq_pkg::SRC_A];
      assign clr_v[g] = ((wr_ok && int'(wch) == g && wreg == qcirq_pkg::REG_FLAG && s_axi_wstrb[0])
                        ? ~s_axi_wdata[5:0] : 6'h00) | {5'h00, dma_ack_i[g]};
    end
  endgenerate

  assign wch           = s_axi_awaddr[7:5];
  assign wreg          = s_axi_awaddr[4:2];
  assign rch           = s_axi_araddr[7:5];
  assign rreg          = s_axi_araddr[4:2];
  assign wr_fire       = s_axi_awvalid && s_axi_wvalid && !qs.bvalid;
  assign wr_ok         = wr_fire && reg_ok(wch, wreg);
  assign s_axi_awready = wr_fire;
  assign s_axi_wready  = wr_fire;
  assign s_axi_arready = !qs.rvalid;
  assign s_axi_bvalid  = qs.bvalid;
  assign s_axi_bresp   = qs.bresp;
  assign s_axi_rvalid  = qs.rvalid;
  assign s_axi_rresp   = qs.rresp;
  assign s_axi_rdata   = qs.rdata;

  always_comb begin
    qd = qs;
    for (int c = 0; c < qcirq_pkg::NCH; c++) begin
      // on channels 1, 2, 4 and 5 phase mode overrides the free-running internal count
      if (qs.ctl[c][qcirq_pkg::CTL_PHASE] && !qcirq_pkg::has_four(c)) begin
        cup[c] = qs.ctl[c][qcirq_pkg::CTL_RUN] && dec_up[c];
        cdn[c] = qs.ctl[c][qcirq_pkg::CTL_RUN] && dec_dn[c];
      end else begin
        cup[c] = qs.ctl[c][qcirq_pkg::CTL_RUN];
        cdn[c] = 1'b0;
      end
      cnt_n[c] = cup[c] ? qs.cnt[c] + qcirq_pkg::CNT_ONE
               : cdn[c] ? qs.cnt[c] - qcirq_pkg::CNT_ONE : qs.cnt[c];
      ovf[c] = cup[c] && qs.cnt[c] == qcirq_pkg::CNT_MAX;
      unf[c] = cdn[c] && qs.cnt[c] == qcirq_pkg::CNT_MIN;
      for (int x = 0; x < 4; x++) begin
        match[c][x] = (cup[c] || cdn[c]) && cnt_n[c] == qs.gr[c][x];
      end
      set_v[c] = {unf[c], ovf[c], match[c]};
      qd.cnt[c] = cnt_n[c];
      qd.dir[c] = cdn[c] ? 1'b1 : (cup[c] ? 1'b0 : qs.dir[c]);
    end
    // encoder coupling between channels 0 and 1
    capb0 = qs.ctl[0][qcirq_pkg::CTL_CAPB] && (cup[1] || cdn[1]);
    capa1 = qs.ctl[1][qcirq_pkg::CTL_CAPA] && match[0][qcirq_pkg::SRC_A];
    capb1 = qs.ctl[1][qcirq_pkg::CTL_CAPB] && match[0][qcirq_pkg::SRC_C];
    if (qs.ctl[0][qcirq_pkg::CTL_CAPB]) set_v[0][qcirq_pkg::SRC_B] = capb0;
    if (qs.ctl[0][qcirq_pkg::CTL_BUF]) set_v[0][qcirq_pkg::SRC_D] = 1'b0;
    if (qs.ctl[1][qcirq_pkg::CTL_CAPA]) set_v[1][qcirq_pkg::SRC_A] = capa1;
    if (qs.ctl[1][qcirq_pkg::CTL_CAPB]) set_v[1][qcirq_pkg::SRC_B] = capb1;
    if (capb0) begin
      if (qs.ctl[0][qcirq_pkg::CTL_BUF]) qd.gr[0][3] = qs.gr[0][1];
      qd.gr[0][1] = cnt_n[0];
    end
    if (capa1) qd.gr[1][0] = cnt_n[1];
    if (capb1) qd.gr[1][1] = cnt_n[1];
    // a bus write to cnt or gr beats a count or capture in the same cycle
    if (qs.bvalid && s_axi_bready) qd.bvalid = 1'b0;
    if (wr_fire) begin
      qd.bvalid = 1'b1;
      qd.bresp  = wr_ok ? qcirq_pkg::RESP_OK : qcirq_pkg::RESP_ERR;
      if (wr_ok) begin
        case (wreg)
          qcirq_pkg::REG_CTRL: begin
            if (s_axi_wstrb[0]) qd.ctl[wch] = s_axi_wdata[7:0];
          end
          qcirq_pkg::REG_IER: begin
            if (s_axi_wstrb[0]) qd.ier[wch] = s_axi_wdata[5:0] & qcirq_pkg::src_mask(int'(wch));
          end
          qcirq_pkg::REG_FLAG: begin
          end
          qcirq_pkg::REG_CNT: begin
            qd.cnt[wch] = merge16(qs.cnt[wch], s_axi_wdata, s_axi_wstrb);
          end
          default: begin
            qd.gr[wch][wreg[1:0]] = merge16(qs.gr[wch][wreg[1:0]], s_axi_wdata, s_axi_wstrb);
          end
        endcase
      end
    end
    if (qs.rvalid && s_axi_rready) qd.rvalid = 1'b0;
    if (s_axi_arvalid && !qs.rvalid) begin
      qd.rvalid = 1'b1;
      qd.rdata  = '0;
      qd.rresp  = qcirq_pkg::RESP_ERR;
      if (reg_ok(rch, rreg)) begin
        qd.rresp = qcirq_pkg::RESP_OK;
        case (rreg)
          qcirq_pkg::REG_CTRL: qd.rdata[7:0]  = qs.ctl[rch];
          qcirq_pkg::REG_IER:  qd.rdata[5:0]  = qs.ier[rch];
          qcirq_pkg::REG_FLAG: qd.rdata[7:0]  = {qs.dir[rch], 1'b0, flags[rch]};
          qcirq_pkg::REG_CNT:  qd.rdata[15:0] = qs.cnt[rch];
          default:             qd.rdata[15:0] = qs.gr[rch][rreg[1:0]];
        endcase
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (!resetn_i) qs <= '0;
    else qs <= qd;
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!resetn_i);

  sequence ch1_tick_s;
    qs.ctl[0][qcirq_pkg::CTL_CAPB] && (cup[1] || cdn[1]) && !wr_fire;
  endsequence
  sequence ch0_match_a_s;
    qs.ctl[1][qcirq_pkg::CTL_CAPA] && match[0][qcirq_pkg::SRC_A] && !wr_fire;
  endsequence

  ovf_flag_a: assert property (cup[2] && qs.cnt[2] == qcirq_pkg::CNT_MAX |=> flags[2][qcirq_pkg::SRC_V] && qs.cnt[2] == qcirq_pkg::CNT_MIN) else $error("overflow not flagged");
  unf_flag_a: assert property (cdn[1] && qs.cnt[1] == qcirq_pkg::CNT_MIN |=> flags[1][qcirq_pkg::SRC_U] && qs.cnt[1] == qcirq_pkg::CNT_MAX) else $error("underflow not flagged");
  cap_b0_a: assert property (ch1_tick_s |=> qs.gr[0][1] == qs.cnt[0] && flags[0][qcirq_pkg::SRC_B]) else $error("count clock capture missed");
  buf_copy_a: assert property (ch1_tick_s ##0 qs.ctl[0][qcirq_pkg::CTL_BUF] |=> qs.gr[0][3] == $past(qs.gr[0][1])) else $error("buffer not loaded");
  cap_a1_a: assert property (ch0_match_a_s |=> qs.gr[1][0] == qs.cnt[1] && flags[1][qcirq_pkg::SRC_A]) else $error("match capture missed");
  no_phase_a: assert property (qs.ctl[3][qcirq_pkg::CTL_RUN] && !wr_fire |=> qs.cnt[3] == $past(qs.cnt[3]) + qcirq_pkg::CNT_ONE) else $error("channel 3 left internal count");
  pin_share_a: assert property ((qs.ctl[1][7:2] == qs.ctl[5][7:2] && $stable(qs.ctl[1]) && $stable(qs.ctl[5])) [*4] |-> dec_up[1] == dec_up[5]) else $error("pin map differs");
  src_set_a: assert property (!flags[0][qcirq_pkg::SRC_U] && !flags[3][qcirq_pkg::SRC_U] && !flags[2][qcirq_pkg::SRC_C] && !flags[5][qcirq_pkg::SRC_D]) else $error("absent source flagged");
  dma_a_only_a: assert property (dma_req_o[4] |-> flags[4][qcirq_pkg::SRC_A] && qs.ier[4][qcirq_pkg::SRC_A]) else $error("dma from wrong source");
  irq_gate_a: assert property (flags[2][qcirq_pkg::SRC_V] && !qs.ier[2][qcirq_pkg::SRC_V] |-> !src_irq_o[2*6 + qcirq_pkg::SRC_V]) else $error("masked request seen");
endmodule // qcirq_top

// File: test_quadrature_count_and_irq.sv
// Purpose: self-checking bench of the quadrature counter and flag block
// Assumes: AXI4-Lite master tasks, two encoder models on the phase pins
// Notes: read and write answers are checked by a monitor from queued notes
`timescale 1ns/1ns
module test_quadrature_count_and_irq;
  typedef struct packed {
    logic [31:0] data;
    logic [31:0] mask;
    logic [1:0]  resp;
  } qcirq_note_s;
  logic        clk_i    = 1'b0;
  logic        resetn_i = 1'b0;
  logic [7:0]  awaddr   = 8'h00;
  logic [7:0]  araddr   = 8'h00;
  logic [31:0] wdata    = 32'h0000_0000;
  logic        awvalid  = 1'b0;
  logic        wvalid   = 1'b0;
  logic        bready   = 1'b0;
  logic        arvalid  = 1'b0;
  logic        rready   = 1'b0;
  logic [5:0]  dma_ack  = 6'h00;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [1:0]  bresp, rresp;
  logic [31:0] rdata;
  logic        pin_a, pin_b, pin_c, pin_d;
  logic [35:0] src_irq;
  logic [5:0]  ch_irq, dma_req;
  logic [17:0] ch_irq_src;
  qcirq_note_s rd_q[$];
  logic [1:0]  wr_q[$];
  int          num_errors  = 0;
  int          comparisons = 0;

  always #50 clk_i = ~clk_i;

  qcirq_top DUT (
    .clk_i(clk_i), .resetn_i(resetn_i),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .ext_clock_pin_a_i(pin_a), .ext_clock_pin_b_i(pin_b),
    .ext_clock_pin_c_i(pin_c), .ext_clock_pin_d_i(pin_d),
    .dma_ack_i(dma_ack), .src_irq_o(src_irq), .ch_irq_o(ch_irq),
    .ch_irq_src_o(ch_irq_src), .dma_req_o(dma_req)
  );
  qcirq_enc_model enc_ab (.clk_i(clk_i), .a_o(pin_a), .b_o(pin_b));
  qcirq_enc_model enc_cd (.clk_i(clk_i), .a_o(pin_c), .b_o(pin_d));

  task automatic check_val(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic check_bit(input string what, input logic exp, input logic got);
    check_val(what, {31'h0, exp}, {31'h0, got});
  endtask

  task automatic give_verdict();
    $display("comparisons %0d num_errors %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // a leading edge keeps each strobe to one assignment per time step
  task automatic rd(input int ch, input int wd, input logic [31:0] exp,
                    input logic [31:0] mask = 32'hFFFF_FFFF, input logic [1:0] resp = 2'h0);
    @(posedge clk_i);
    rd_q.push_back('{exp, mask, resp});
    araddr  <= 8'(ch * 32 + wd * 4);
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do @(posedge clk_i); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge clk_i); while (rvalid !== 1'b1);
    rready <= 1'b0;
  endtask

  task automatic wr(input int ch, input int wd, input logic [31:0] data,
                    input logic [1:0] resp = 2'h0);
    @(posedge clk_i);
    wr_q.push_back(resp);
    awaddr <= 8'(ch * 32 + wd * 4);
    wdata  <= data;
    {awvalid, wvalid, bready} <= 3'h7;
    do @(posedge clk_i); while (awready !== 1'b1 || wready !== 1'b1);
    {awvalid, wvalid} <= 2'h0;
    do @(posedge clk_i); while (bvalid !== 1'b1);
    bready <= 1'b0;
  endtask

  always @(posedge clk_i) begin
    if (rvalid && rready && rd_q.size() > 0) begin
      check_val("rdata", rd_q[0].data & rd_q[0].mask, rdata & rd_q[0].mask);
      check_val("rresp", rd_q[0].resp, rresp);
      void'(rd_q.pop_front());
    end
    if (bvalid && bready && wr_q.size() > 0)
      check_val("bresp", wr_q.pop_front(), bresp);
  end

  initial begin
    #(100 * 40000);
    num_errors++;
    give_verdict();
  end

  initial begin
    int n, r, h, k;
    void'($urandom(92144));
    repeat (8) @(posedge clk_i);
    resetn_i <= 1'b1;
    rd(0, qcirq_pkg::REG_CTRL, 32'h0);
    rd(3, qcirq_pkg::REG_FLAG, 32'h0);
    rd(1, 6, 32'h0, 32'hFFFF_FFFF, qcirq_pkg::RESP_ERR);
    rd(6, 0, 32'h0, 32'hFFFF_FFFF, qcirq_pkg::RESP_ERR);
    wr(7, 1, 32'h3F, qcirq_pkg::RESP_ERR);
    wr(0, qcirq_pkg::REG_IER, 32'h3F);
    rd(0, qcirq_pkg::REG_IER, 32'h1F); // four matches and overflow
    wr(1, qcirq_pkg::REG_IER, 32'h3F);
    rd(1, qcirq_pkg::REG_IER, 32'h33); // two matches, overflow, underflow
    for (int m = 0; m < 4; m++) begin
      k = (m == 0) ? 4 : ((m == 3) ? 2 : 1);
      n = 1 + $urandom % 4;
      r = $urandom % 4;
      h = 3 + $urandom % 4;
      wr(1, qcirq_pkg::REG_CTRL, 32'(3 + (m << 2)));
      wr(1, qcirq_pkg::REG_CNT, 32'h0);
      enc_ab.move(1'b1, n, h);
      enc_ab.move(1'b0, r, h);
      repeat (4) @(posedge clk_i);
      rd(1, qcirq_pkg::REG_CNT, 32'(16'(k * (n - r))), 32'h0000_FFFF); // net
    end
    wr(2, qcirq_pkg::REG_CTRL, 32'h0F);
    enc_cd.move(1'b1, 2, 3);
    repeat (4) @(posedge clk_i);
    rd(2, qcirq_pkg::REG_CNT, 32'h4, 32'h0000_FFFF); // count from pins c and d
    wr(1, qcirq_pkg::REG_CTRL, 32'h07);
    wr(1, qcirq_pkg::REG_IER, 32'h20);
    wr(1, qcirq_pkg::REG_CNT, 32'h0);
    wr(1, qcirq_pkg::REG_FLAG, 32'h0);
    enc_ab.move(1'b0, 1, 3);
    repeat (4) @(posedge clk_i);
    rd(1, qcirq_pkg::REG_FLAG, 32'hA0, 32'hB0); // underflow and down
    check_bit("underflow irq", 1'b1, src_irq[11]); // enabled source
    check_bit("ch1 irq", 1'b1, ch_irq[1]); // channel line
    check_val("ch1 source", 32'h5, ch_irq_src[5:3]); // sole source
    enc_ab.move(1'b1, 1, 3);
    repeat (4) @(posedge clk_i);
    rd(1, qcirq_pkg::REG_FLAG, 32'h30, 32'hB0); // overflow and up
    check_bit("held underflow", 1'b1, src_irq[11]); // still pending
    check_bit("masked overflow", 1'b0, src_irq[10]); // enable off
    wr(1, qcirq_pkg::REG_FLAG, 32'hDF);
    check_bit("cleared underflow", 1'b0, src_irq[11]); // drop on clear
    rd(1, qcirq_pkg::REG_FLAG, 32'h10, 32'h30); // zero clears, one
    wr(1, qcirq_pkg::REG_CNT, 32'h1234);
    wr(1, qcirq_pkg::REG_CTRL, 32'h37);
    wr(0, qcirq_pkg::REG_GRA, 32'h40);
    wr(0, qcirq_pkg::REG_GRC, 32'h80);
    wr(0, qcirq_pkg::REG_CTRL, 32'h1);
    repeat (200) @(posedge clk_i);
    wr(0, qcirq_pkg::REG_CTRL, 32'h0);
    rd(0, qcirq_pkg::REG_FLAG, 32'h05, 32'h1F); // matches a and c
    rd(1, qcirq_pkg::REG_GRA, 32'h1234); // capture on ch0 match a
    rd(1, qcirq_pkg::REG_GRA + 1, 32'h1234); // capture on ch0 match c
    check_val("ch0 source", 32'h0, ch_irq_src[2:0]); // a ahead of c
    check_bit("dma a", 1'b1, dma_req[0]); // match a requests dma
    dma_ack <= 6'h01;
    @(posedge clk_i);
    dma_ack <= 6'h00;
    repeat (2) @(posedge clk_i);
    check_bit("dma after ack", 1'b0, dma_req[0]); // match c gives no dma
    check_val("ch0 source", 32'h2, ch_irq_src[2:0]); // c next
    give_verdict();
  end
endmodule // test_quadrature_count_and_irq
